// file: core/sideband_pkg.sv
package sideband_pkg;
	// bus widths kept by the reversal strap
	localparam int DATA_W = 64;
	localparam int ADDR_HI = 31;
	localparam int ADDR_LO = 3;
	localparam int ADDR_W = ADDR_HI - ADDR_LO + 1;
	localparam int INV_W = 4;
	// synchroniser depth and reset drain bound
	localparam int SYNC_STAGES = 2;
	localparam int RESET_OFF_CLKS = 2;
	// local irq input positions
	localparam int LIRQ_MASKABLE = 0;
	localparam int LIRQ_NONMASK = 1;
	// reset values
	localparam logic LIRQ_CTRL_EN_RST = 1'b1;
	localparam logic REVERSE_RST = 1'b0;

	// lines routed to the core interrupt logic
	typedef struct packed {
		logic maskable_irq;
		logic nonmask_irq;
		logic [1:0] local_irq;
	} irq_route_t;

	// one bus word as seen by the core
	typedef struct packed {
		logic [DATA_W-1:0] data;
		logic [ADDR_W-1:0] addr;
		logic [INV_W-1:0] inv;
	} bus_word_t;

	typedef enum logic [1:0] {
		LOCK_IDLE,
		LOCK_HELD
	} lock_state_t;
endpackage : sideband_pkg

// file: core/sync_bits.sv
`timescale 1ns/1ps
`default_nettype none
// multi-bit level synchroniser; stage one feeds only stage two
module sync_bits #(
	parameter int W = 1
) (
	// clock
	input wire logic clk_sys,
	// async in, synced out
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	// two flops, the first read by nothing else
	// no reset: a strap must see the pin as it stands when reset goes away
	always_ff @(posedge clk_sys) begin
		meta_q <= async_in;
		sync_q <= meta_q;
	end
	assign sync_out = sync_q;
endmodule : sync_bits
`default_nettype wire

// file: core/cpu_sideband.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// RQ1 - soft init pulses integer register reset; cache and FP state left alone
// RQ2 - after soft init, execution restarts at configured reset vector
// RQ3 - snoop responses keep flowing while soft init is held
// RQ4 - chipset presents soft init valid with target ready of I/O write; chipset_model drives the pin straight from init_cmd
// RQ5 - soft init high at reset release reverses data, address and invert lines
// RQ6 - irq controller disabled: local irq zero becomes maskable irq
// RQ7 - irq controller disabled: local irq one becomes non-maskable irq
// RQ8 - irq controller enabled after reset; pins act as local irq inputs
// RQ9 - bus lock held from first locked transaction start to last end
// RQ10 - priority agent waits for bus lock deasserted before taking bus
// RQ11 - thermal pin driven active when sensor reports maximum temperature
// RQ12 - thermal control engaged while system holds pin active, if enabled
// RQ13 - async soft init and local irq inputs pass two flip-flop synchroniser
// RQ14 - all outputs released within two clocks of reset asserted
module cpu_sideband (
	// clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// soft init pin, async
	input wire logic soft_init_n,
	// local irq pins, async
	input wire logic [1:0] local_irq_in,
	// irq controller enable from core software config
	input wire logic cfg_wr,
	input wire logic cfg_lirq_ctrl_en,
	output logic local_irq_controller_en,
	output sideband_pkg::irq_route_t irq_route,
	// core restart control
	output logic int_reg_reset,
	output logic restart_at_vector,
	output logic core_hold,
	// snoop path, kept alive during soft init
	input wire logic snoop_req,
	output logic snoop_ack,
	// bus words and their reversed forms
	input wire sideband_pkg::bus_word_t pin_word,
	output sideband_pkg::bus_word_t core_word,
	output logic reverse_active,
	// locked sequence from core
	input wire logic lock_seq_start,
	input wire logic lock_seq_end,
	output logic bus_lock_n,
	// thermal throttle pin, open drain
	input wire logic temp_max_hit,
	input wire logic thermal_ctrl_en,
	input wire logic thermal_throttle_in_n,
	output logic thermal_throttle_out_n,
	output logic thermal_throttle_oe_n,
	output logic thermal_control_unit_on
);
	logic [2:0] sync_v;
	logic init_s;
	logic [1:0] lirq_s;
	logic init_prev_q;
	logic init_rise;
	logic init_fall;
	logic rst_prev_q;
	logic rst_release;
	logic reverse_q;
	logic lirq_en_q;
	logic int_reset_q;
	logic restart_q;
	logic snoop_ack_q;
	sideband_pkg::bus_word_t word_q;
	sideband_pkg::bus_word_t word_rev;
	sideband_pkg::lock_state_t lock_q;
	sideband_pkg::lock_state_t lock_d;
	logic thermal_drive_q;
	logic thermal_pin_q;
	logic thermal_on_q;

	// async pins synchronised before any use
	sync_bits #(.W(3)) u_sync ( // RQ13
		.clk_sys(clk_sys),
		.async_in({~soft_init_n, local_irq_in}),
		.sync_out(sync_v)
	);
	assign init_s = sync_v[2];
	assign lirq_s = sync_v[1:0] & {2{~sys_rst}}; // RQ14 synchroniser is unreset, so mask here
	assign init_rise = init_s & ~init_prev_q;
	assign init_fall = ~init_s & init_prev_q;
	assign rst_release = rst_prev_q & ~sys_rst;

	// strap caught on the cycle reset goes away; cleared while reset is held
	always_ff @(posedge clk_sys) begin
		rst_prev_q <= sys_rst;
		if (rst_release) begin
			reverse_q <= init_s; // RQ5
		end else if (sys_rst) begin
			reverse_q <= sideband_pkg::REVERSE_RST;
		end
	end

	// init edge tracking; reset forces idle so a held pin restarts cleanly
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			init_prev_q <= 1'b0;
			int_reset_q <= 1'b0;
			restart_q <= 1'b0;
		end else begin
			init_prev_q <= init_s;
			int_reset_q <= init_rise; // RQ1
			restart_q <= init_fall; // RQ2
		end
	end
	assign int_reg_reset = int_reset_q;
	assign restart_at_vector = restart_q;
	assign core_hold = init_prev_q;

	// snoops answered one cycle later whatever init does
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			snoop_ack_q <= 1'b0;
		end else begin
			snoop_ack_q <= snoop_req; // RQ3
		end
	end
	assign snoop_ack = snoop_ack_q;

	// irq controller enable; default on after reset
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			lirq_en_q <= sideband_pkg::LIRQ_CTRL_EN_RST; // RQ8
		end else if (cfg_wr) begin
			lirq_en_q <= cfg_lirq_ctrl_en;
		end
	end
	assign local_irq_controller_en = lirq_en_q;
	assign irq_route.local_irq = lirq_en_q ? lirq_s : 2'h0;
	assign irq_route.maskable_irq = ~lirq_en_q & lirq_s[sideband_pkg::LIRQ_MASKABLE]; // RQ6
	assign irq_route.nonmask_irq = ~lirq_en_q & lirq_s[sideband_pkg::LIRQ_NONMASK]; // RQ7

	// bit reversal of each field in one loop per width
	for (genvar i = 0; i < sideband_pkg::DATA_W; i++) begin : g_d
		assign word_rev.data[i] = pin_word.data[sideband_pkg::DATA_W-1-i];
	end
	for (genvar i = 0; i < sideband_pkg::ADDR_W; i++) begin : g_a
		assign word_rev.addr[i] = pin_word.addr[sideband_pkg::ADDR_W-1-i];
	end
	for (genvar i = 0; i < sideband_pkg::INV_W; i++) begin : g_v
		assign word_rev.inv[i] = pin_word.inv[sideband_pkg::INV_W-1-i];
	end

	// registered word; reversal costs nothing at run time
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			word_q <= '0;
		end else begin
			word_q <= reverse_q ? word_rev : pin_word; // RQ5
		end
	end
	assign core_word = word_q;
	assign reverse_active = reverse_q;

	// lock spans from first start to last end; reset drops it at once
	always_comb begin
		lock_d = lock_q;
		case (lock_q)
			sideband_pkg::LOCK_IDLE: begin
				if (lock_seq_start) lock_d = sideband_pkg::LOCK_HELD;
			end
			sideband_pkg::LOCK_HELD: begin
				if (lock_seq_end) lock_d = sideband_pkg::LOCK_IDLE;
			end
			default: lock_d = sideband_pkg::LOCK_IDLE;
		endcase
	end
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			lock_q <= sideband_pkg::LOCK_IDLE; // RQ14
		end else begin
			lock_q <= lock_d; // RQ9
		end
	end
	assign bus_lock_n = ~(lock_q == sideband_pkg::LOCK_HELD); // RQ10

	// thermal: drive on overheat, follow system drive; own drive excluded
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			thermal_drive_q <= 1'b0;
			thermal_pin_q <= 1'b0;
			thermal_on_q <= 1'b0;
		end else begin
			thermal_drive_q <= temp_max_hit; // RQ11
			thermal_pin_q <= ~thermal_throttle_in_n & ~thermal_drive_q;
			thermal_on_q <= thermal_ctrl_en & (temp_max_hit | thermal_pin_q); // RQ12
		end
	end
	assign thermal_throttle_out_n = 1'b0;
	assign thermal_throttle_oe_n = ~thermal_drive_q; // RQ11
	assign thermal_control_unit_on = thermal_on_q;

	// reset drains bus lock, thermal pin drive and snoop ack inside the bound
	property p_reset_drain;
		@(posedge clk_sys) sys_rst |-> ##[1:2] (bus_lock_n && thermal_throttle_oe_n && !snoop_ack);
	endproperty
	a_reset_drain: assert property (p_reset_drain) else $error("outputs not released under reset"); // RQ14

	sequence s_init_rise;
		!init_s ##1 init_s;
	endsequence
	property p_int_reset;
		@(posedge clk_sys) disable iff (sys_rst) s_init_rise |=> int_reg_reset;
	endproperty
	a_int_reset: assert property (p_int_reset) else $error("integer reset pulse missing"); // RQ1

	property p_restart;
		@(posedge clk_sys) disable iff (sys_rst) (init_prev_q && !init_s) |=> restart_at_vector ##1 !restart_at_vector;
	endproperty
	a_restart: assert property (p_restart) else $error("restart pulse wrong"); // RQ2

	property p_snoop;
		@(posedge clk_sys) disable iff (sys_rst) (snoop_req && core_hold) |=> snoop_ack;
	endproperty
	a_snoop: assert property (p_snoop) else $error("snoop dropped during init"); // RQ3

	property p_strap;
		@(posedge clk_sys) $fell(sys_rst) |=> reverse_active == $past(init_s);
	endproperty
	a_strap: assert property (p_strap) else $error("strap not caught"); // RQ5

	property p_maskable;
		@(posedge clk_sys) disable iff (sys_rst) !local_irq_controller_en |-> irq_route.maskable_irq == lirq_s[0];
	endproperty
	a_maskable: assert property (p_maskable) else $error("maskable irq route wrong"); // RQ6

	property p_nonmask;
		@(posedge clk_sys) disable iff (sys_rst) !local_irq_controller_en |-> irq_route.nonmask_irq == lirq_s[1];
	endproperty
	a_nonmask: assert property (p_nonmask) else $error("non-maskable route wrong"); // RQ7

	property p_lirq_default;
		@(posedge clk_sys) $fell(sys_rst) |-> local_irq_controller_en && irq_route.maskable_irq == 1'b0;
	endproperty
	a_lirq_default: assert property (p_lirq_default) else $error("irq controller not on after reset"); // RQ8

	property p_lock_hold;
		@(posedge clk_sys) disable iff (sys_rst) (!bus_lock_n && !lock_seq_end) |=> !bus_lock_n;
	endproperty
	a_lock_hold: assert property (p_lock_hold) else $error("lock dropped early"); // RQ9

	property p_thermal;
		@(posedge clk_sys) disable iff (sys_rst) temp_max_hit |=> !thermal_throttle_oe_n;
	endproperty
	a_thermal: assert property (p_thermal) else $error("thermal pin not driven"); // RQ11

	property p_thermal_in;
		@(posedge clk_sys) disable iff (sys_rst) (thermal_ctrl_en && thermal_pin_q) |=> thermal_control_unit_on;
	endproperty
	a_thermal_in: assert property (p_thermal_in) else $error("thermal control not engaged"); // RQ12

	property p_sync;
		@(posedge clk_sys) disable iff (sys_rst) ##2 (init_s == !$past(soft_init_n, 2));
	endproperty
	a_sync: assert property (p_sync) else $error("sync depth wrong"); // RQ13
endmodule : cpu_sideband
`default_nettype wire

// file: testbench/chipset_model.sv
`timescale 1ns/1ps
`default_nettype none
// chipset end of the sideband pins, steered by the bench
module chipset_model (
	// commands from the bench
	input wire logic init_cmd,
	input wire logic [1:0] irq_cmd,
	input wire logic hot_cmd,
	input wire logic prio_cmd,
	// pins shared with the device
	input wire logic bus_lock_n,
	input wire logic therm_oe_n,
	input wire logic therm_out_n,
	output logic soft_init_n,
	output logic [1:0] local_irq_in,
	output logic therm_wire_n,
	output logic prio_owns
);
	// init pin follows the bench init command directly, active low; no io write or target ready is modelled
	assign soft_init_n = ~init_cmd;
	assign local_irq_in = irq_cmd;
	// open drain with pull-up: low if either side sinks it
	assign therm_wire_n = ~hot_cmd & (therm_oe_n | therm_out_n);
	// priority agent takes the bus only once lock is released
	assign prio_owns = prio_cmd & bus_lock_n;
endmodule : chipset_model
`default_nettype wire

// file: testbench/cpu_sideband_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_sideband_tb;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic init_cmd = 1'b0, hot_cmd = 1'b0, prio_cmd = 1'b0, cfg_wr = 1'b0, cfg_lirq_ctrl_en = 1'b1;
	logic snoop_req = 1'b0, lock_seq_start = 1'b0, lock_seq_end = 1'b0;
	logic temp_max_hit = 1'b0, thermal_ctrl_en = 1'b1;
	logic [1:0] irq_cmd = 2'h0;
	logic [1:0] local_irq_in;
	sideband_pkg::bus_word_t pin_word = '0;
	sideband_pkg::bus_word_t core_word, w;
	sideband_pkg::irq_route_t irq_route;
	logic soft_init_n, therm_wire_n, therm_out_n, therm_oe_n, prio_owns, lirq_en, int_reg_reset;
	logic restart_at_vector, core_hold, snoop_ack, reverse_active, bus_lock_n, tcu_on;
	int fail_count = 0;
	int cmp_count = 0;
	int n;

	chipset_model cs (.init_cmd(init_cmd), .irq_cmd(irq_cmd), .hot_cmd(hot_cmd), .prio_cmd(prio_cmd),
		.bus_lock_n(bus_lock_n), .therm_oe_n(therm_oe_n), .therm_out_n(therm_out_n),
		.soft_init_n(soft_init_n), .local_irq_in(local_irq_in), .therm_wire_n(therm_wire_n),
		.prio_owns(prio_owns));
	cpu_sideband DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .soft_init_n(soft_init_n),
		.local_irq_in(local_irq_in), .cfg_wr(cfg_wr), .cfg_lirq_ctrl_en(cfg_lirq_ctrl_en),
		.local_irq_controller_en(lirq_en), .irq_route(irq_route), .int_reg_reset(int_reg_reset),
		.restart_at_vector(restart_at_vector), .core_hold(core_hold), .snoop_req(snoop_req),
		.snoop_ack(snoop_ack), .pin_word(pin_word), .core_word(core_word), .reverse_active(reverse_active),
		.lock_seq_start(lock_seq_start), .lock_seq_end(lock_seq_end), .bus_lock_n(bus_lock_n),
		.temp_max_hit(temp_max_hit), .thermal_ctrl_en(thermal_ctrl_en), .thermal_throttle_in_n(therm_wire_n),
		.thermal_throttle_out_n(therm_out_n), .thermal_throttle_oe_n(therm_oe_n), .thermal_control_unit_on(tcu_on));

	// 125 MHz clock
	initial begin
		forever #4 clk_sys = ~clk_sys;
	end

	task automatic check(input logic [127:0] seen, input logic [127:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// lands just after the edge so registered outputs have settled
	task automatic tick(input int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask : tick

	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : give_verdict

	// bits of each field mirrored in place as the core sees them under the strap
	function automatic sideband_pkg::bus_word_t rev(input sideband_pkg::bus_word_t x);
		for (int i = 0; i < sideband_pkg::DATA_W; i++) rev.data[i] = x.data[sideband_pkg::DATA_W-1-i];
		for (int i = 0; i < sideband_pkg::ADDR_W; i++) rev.addr[i] = x.addr[sideband_pkg::ADDR_W-1-i];
		for (int i = 0; i < sideband_pkg::INV_W; i++) rev.inv[i] = x.inv[sideband_pkg::INV_W-1-i];
	endfunction : rev

	function automatic sideband_pkg::bus_word_t rnd_word();
		logic [127:0] r;
		r = {$urandom(), $urandom(), $urandom(), $urandom()};
		rnd_word = r[96:0];
	endfunction : rnd_word

	function automatic sideband_pkg::irq_route_t route_exp(input logic en, input logic [1:0] p);
		route_exp = en ? {2'h0, p} : {p[0], p[1], 2'h0};
	endfunction : route_exp

	// generous bound: the sequence needs about 130 cycles
	initial begin
		#40000;
		fail_count++;
		give_verdict();
	end

	initial begin
		void'($urandom(38));
		tick(9);
		check({bus_lock_n, therm_oe_n, lirq_en}, 3'h7);
		@(posedge clk_sys) sys_rst <= 1'b0;
		tick(3);
		check(reverse_active, 1'h0);
		check(lirq_en, 1'h1);
		// straight word path while the strap was clear
		repeat (3) begin
			@(posedge clk_sys);
			w = rnd_word();
			pin_word <= w;
			tick(1);
			check(core_word, w);
		end
		// every pin code, controller on then off
		for (int e = 1; e >= 0; e--) begin
			if (e == 0) begin
				@(posedge clk_sys);
				cfg_wr <= 1'b1;
				cfg_lirq_ctrl_en <= 1'b0;
				@(posedge clk_sys) cfg_wr <= 1'b0;
				#1;
				check(lirq_en, 1'h0);
			end
			for (int k = 0; k < 4; k++) begin
				@(posedge clk_sys) irq_cmd <= k[1:0];
				tick(3);
				check(irq_route, route_exp(e[0], k[1:0]));
			end
		end
		// soft init with a snoop in the middle
		@(posedge clk_sys) init_cmd <= 1'b1;
		tick(3);
		check({int_reg_reset, core_hold}, 2'h3);
		tick(1);
		check(int_reg_reset, 1'h0);
		@(posedge clk_sys) snoop_req <= 1'b1;
		@(posedge clk_sys) snoop_req <= 1'b0;
		#1;
		check(snoop_ack, 1'h1);
		@(posedge clk_sys) init_cmd <= 1'b0;
		tick(3);
		check({restart_at_vector, core_hold}, 2'h2);
		tick(1);
		check(restart_at_vector, 1'h0);
		// locked run of random length, priority agent waiting
		@(posedge clk_sys) lock_seq_start <= 1'b1;
		@(posedge clk_sys);
		lock_seq_start <= 1'b0;
		prio_cmd <= 1'b1;
		n = 2 + $urandom % 8;
		repeat (n) begin
			tick(1);
			check({bus_lock_n, prio_owns}, 2'h0);
		end
		@(posedge clk_sys) lock_seq_end <= 1'b1;
		@(posedge clk_sys) lock_seq_end <= 1'b0;
		#1;
		check({bus_lock_n, prio_owns}, 2'h3);
		// own sensor trip drives the pin
		@(posedge clk_sys) temp_max_hit <= 1'b1;
		tick(1);
		check({therm_oe_n, therm_out_n, tcu_on}, 3'h1);
		@(posedge clk_sys) temp_max_hit <= 1'b0;
		tick(4);
		// system holds the pin, control follows the enable
		for (int e = 1; e >= 0; e--) begin
			@(posedge clk_sys);
			thermal_ctrl_en <= e[0];
			hot_cmd <= 1'b1;
			tick(2);
			check(tcu_on, e[0]);
			tick(4);
			check(tcu_on, e[0]);
			@(posedge clk_sys) hot_cmd <= 1'b0;
			tick(2);
			check(tcu_on, 1'h0);
		end
		// reset during a lock and a trip, init held for the strap
		@(posedge clk_sys);
		lock_seq_start <= 1'b1;
		temp_max_hit <= 1'b1;
		thermal_ctrl_en <= 1'b1;
		init_cmd <= 1'b1;
		@(posedge clk_sys);
		lock_seq_start <= 1'b0;
		sys_rst <= 1'b1;
		tick(2);
		check({bus_lock_n, therm_oe_n}, 2'h3);
		@(posedge clk_sys) temp_max_hit <= 1'b0;
		repeat (4) @(posedge clk_sys);
		sys_rst <= 1'b0;
		tick(3);
		check(reverse_active, 1'h1);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_sys);
			w = (i == 0) ? 97'h1 : rnd_word();
			pin_word <= w;
			tick(1);
			check(core_word, rev(w));
		end
		@(posedge clk_sys) init_cmd <= 1'b0;
		tick(4);
		give_verdict();
	end
endmodule : cpu_sideband_tb
`default_nettype wire
